// ---- rtl/tpc_map.svh ----
`ifndef TPC_MAP_SVH
`define TPC_MAP_SVH

// Widths
`define TPC_CNT_W        10
`define TPC_DATA_W       16
`define TPC_ADDR_W       3

// Register word addresses
`define TPC_ADDR_CTRL0   3'h0
`define TPC_ADDR_CTRL1   3'h1
`define TPC_ADDR_COUNT   3'h2
`define TPC_ADDR_CMPA    3'h3
`define TPC_ADDR_CMPP    3'h4

// Field positions
`define TPC_RUN_BIT      0
`define TPC_MODE_HI      7
`define TPC_MODE_LO      6
`define TPC_PINF_HI      5
`define TPC_PINF_LO      4
`define TPC_OC_BIT       3
`define TPC_POL_BIT      2
`define TPC_DPX_BIT      1
`define TPC_CCLR_BIT     0

// Operating mode codes
`define TPC_MODE_CMP     2'h0
`define TPC_MODE_CAP     2'h1
`define TPC_MODE_PWM     2'h2
`define TPC_MODE_TMR     2'h3

// Pin function codes
`define TPC_PINF_00      2'h0
`define TPC_PINF_01      2'h1
`define TPC_PINF_10      2'h2
`define TPC_PINF_11      2'h3

// Reset values
`define TPC_RST_CNT      10'h000

`endif

// ---- rtl/tpc_pkg.sv ----
`include "tpc_map.svh"
`default_nettype none

package tpc_pkg;

    typedef struct packed {
        logic                   runEnable;
        logic [1:0]             modeSelect;
        logic [1:0]             pinFunction;
        logic                   outputInitialLevel;
        logic                   outputPolarity;
        logic                   dutyPeriodExchange;
        logic                   counterClearSelect;
        logic [`TPC_CNT_W-1:0]  counter;
        logic [`TPC_CNT_W-1:0]  compareAValue;
        logic [`TPC_CNT_W-1:0]  comparePValue;
        logic                   extPrev;
        logic                   capPrev;
        logic                   pinLevel;
        logic                   cmpLevel;
        logic                   timerIrq;
        logic [`TPC_DATA_W-1:0] readData;
    } tpc_state_type;

endpackage : tpc_pkg

`default_nettype wire

// ---- rtl/tpc_timer.sv ----
// Overview of operation
// RULE1: Software picks single pulse with mode 10 and pin function 11.
// RULE2: Pulse leading edge starts when run enable rises, from software or hardware.
// RULE3: In single pulse mode the external clock pin can set run enable.
// RULE4: When run enable rises in single pulse, counting and active output start together.
// RULE5: Trailing edge on software clear or comparator A match, which clears run enable.
// RULE6: Single pulse comparator A match raises the timer interrupt request.
// RULE7: Single pulse counter clears only on run rise; match stops it uncleared.
// RULE8: Single pulse ignores compare P, clear select and duty/period exchange.
// RULE9: Software keeps pin function at 11 throughout single pulse use.
// RULE10: Software picks capture mode with mode field 01.
// RULE11: Capture edge is selectable as rising, falling or both.
// RULE12: Capture counter starts when software raises run enable.
// RULE13: Each active capture edge copies counter into compare A and requests interrupt.
// RULE14: Capture counter runs regardless of input, stops only when run falls.
// RULE15: Capture comparator P match clears counter and requests interrupt.
// RULE16: Capture with pin function 11 captures nothing but counter keeps running.
// RULE17: Capture mode drives no output; output, polarity, clear, exchange bits ignored.
// RULE18: Capture with compare P zero lets counter run to maximum and wrap.
// RULE19: PWM waveform keeps running while pin function forces the output level.
// RULE20: PWM ignores the counter clear select bit.
// RULE21: Counter is ten bits and wraps to zero after 3FF.
// RULE22: Capture edge codes: 00 rising, 01 falling, 10 both.
// RULE23: External trigger edge is ignored while a pulse is already active.
`include "tpc_map.svh"
`default_nettype none

module tpc_timer #(
    parameter int CountWidth = `TPC_CNT_W,
    parameter int DataWidth  = `TPC_DATA_W
) (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic [`TPC_ADDR_W-1:0] regAddr,
    input  wire logic [DataWidth-1:0]   regWriteData,
    input  wire logic                   regWrite,
    input  wire logic                   regRead,
    output logic      [DataWidth-1:0]   regReadData,
    input  wire logic                   extTimerClockPin,
    input  wire logic                   captureInputPin,
    output logic                        pulseOut,
    output logic                        timerIrq
);

    // State struct is fixed-width, so only the built widths can be served
    if (CountWidth != `TPC_CNT_W || DataWidth != `TPC_DATA_W)
    begin : g_bad_width
        $error("tpc_timer: unsupported width parameters");
    end

    localparam logic [CountWidth-1:0] CountOne = CountWidth'(1);

    tpc_pkg::tpc_state_type stQ;
    tpc_pkg::tpc_state_type stD;

    logic                  singleMode;
    logic                  captureMode;
    logic                  pwmMode;
    logic                  compareMode;
    logic                  extRise;
    logic                  capRise;
    logic                  capFall;
    logic                  capEdge;
    logic                  aMatch;
    logic                  pMatch;
    logic                  activeLevel;
    logic [CountWidth-1:0] pwmPeriod;
    logic [CountWidth-1:0] pwmDuty;
    logic                  periodEnd;
    logic                  clearByCmp;
    logic                  nextActive;

    always_comb
    begin
        singleMode  = stQ.modeSelect == `TPC_MODE_PWM && stQ.pinFunction == `TPC_PINF_11;
        pwmMode     = stQ.modeSelect == `TPC_MODE_PWM && stQ.pinFunction != `TPC_PINF_11;
        captureMode = stQ.modeSelect == `TPC_MODE_CAP;
        compareMode = stQ.modeSelect == `TPC_MODE_CMP;
        extRise     = extTimerClockPin && !stQ.extPrev;
        capRise     = captureInputPin && !stQ.capPrev;
        capFall     = !captureInputPin && stQ.capPrev;
        aMatch      = stQ.counter == stQ.compareAValue;
        // Zero in compare P never matches, so the count wraps at full scale
        pMatch      = stQ.comparePValue != `TPC_RST_CNT && stQ.counter == stQ.comparePValue; // RULE18
        activeLevel = stQ.outputInitialLevel ^ stQ.outputPolarity;
        // Exchange bit swaps which compare value sets period and duty
        pwmPeriod   = stQ.dutyPeriodExchange ? stQ.compareAValue : stQ.comparePValue;
        pwmDuty     = stQ.dutyPeriodExchange ? stQ.comparePValue : stQ.compareAValue;
        // Period of zero means the full 1024 count
        periodEnd   = stQ.counter + CountOne == pwmPeriod; // RULE20
        clearByCmp  = stQ.counterClearSelect ? aMatch : pMatch;
        unique case (stQ.pinFunction)
            `TPC_PINF_00: capEdge = capRise; // RULE22
            `TPC_PINF_01: capEdge = capFall; // RULE22
            `TPC_PINF_10: capEdge = capRise || capFall; // RULE11
            `TPC_PINF_11: capEdge = 1'b0; // RULE16
        endcase
    end

    always_comb
    begin
        stD          = stQ;
        stD.timerIrq = 1'b0;
        stD.extPrev  = extTimerClockPin;
        stD.capPrev  = captureInputPin;
        stD.readData = '0;

        if (regRead)
        begin
            case (regAddr)
                `TPC_ADDR_CTRL0: stD.readData[`TPC_RUN_BIT] = stQ.runEnable;
                `TPC_ADDR_CTRL1:
                begin
                    stD.readData[`TPC_MODE_HI:`TPC_MODE_LO] = stQ.modeSelect;
                    stD.readData[`TPC_PINF_HI:`TPC_PINF_LO] = stQ.pinFunction;
                    stD.readData[`TPC_OC_BIT]   = stQ.outputInitialLevel;
                    stD.readData[`TPC_POL_BIT]  = stQ.outputPolarity;
                    stD.readData[`TPC_DPX_BIT]  = stQ.dutyPeriodExchange;
                    stD.readData[`TPC_CCLR_BIT] = stQ.counterClearSelect;
                end
                `TPC_ADDR_COUNT: stD.readData[CountWidth-1:0] = stQ.counter;
                `TPC_ADDR_CMPA:  stD.readData[CountWidth-1:0] = stQ.compareAValue;
                `TPC_ADDR_CMPP:  stD.readData[CountWidth-1:0] = stQ.comparePValue;
                default:         stD.readData = '0;
            endcase
        end

        if (regWrite)
        begin
            case (regAddr)
                `TPC_ADDR_CTRL0: stD.runEnable = regWriteData[`TPC_RUN_BIT];
                `TPC_ADDR_CTRL1:
                begin
                    stD.modeSelect         = regWriteData[`TPC_MODE_HI:`TPC_MODE_LO];
                    stD.pinFunction        = regWriteData[`TPC_PINF_HI:`TPC_PINF_LO];
                    stD.outputInitialLevel = regWriteData[`TPC_OC_BIT];
                    stD.outputPolarity     = regWriteData[`TPC_POL_BIT];
                    stD.dutyPeriodExchange = regWriteData[`TPC_DPX_BIT];
                    stD.counterClearSelect = regWriteData[`TPC_CCLR_BIT];
                end
                `TPC_ADDR_CMPA: stD.compareAValue = regWriteData[CountWidth-1:0];
                `TPC_ADDR_CMPP: stD.comparePValue = regWriteData[CountWidth-1:0];
                default:        stD.runEnable = stD.runEnable;
            endcase
        end

        // Hardware trigger only acts from idle, so a retrigger mid-pulse is lost
        if (singleMode && extRise && !stQ.runEnable)
        begin
            stD.runEnable = 1'b1; // RULE3 RULE23
        end

        if (stQ.runEnable)
        begin
            if (singleMode)
            begin
                // Match wins over a software set in the same cycle
                if (aMatch)
                begin
                    stD.runEnable = 1'b0; // RULE5
                    stD.timerIrq  = 1'b1; // RULE6
                end
                else
                begin
                    stD.counter = stQ.counter + CountOne; // RULE8
                end
            end
            else if (captureMode)
            begin
                if (pMatch)
                begin
                    stD.counter  = `TPC_RST_CNT; // RULE15
                    stD.timerIrq = 1'b1; // RULE15
                end
                else
                begin
                    stD.counter = stQ.counter + CountOne; // RULE14 RULE21
                end
            end
            else if (pwmMode)
            begin
                stD.counter  = periodEnd ? `TPC_RST_CNT : stQ.counter + CountOne; // RULE19
                stD.timerIrq = aMatch || pMatch;
            end
            else
            begin
                stD.counter  = clearByCmp ? `TPC_RST_CNT : stQ.counter + CountOne; // RULE21
                stD.timerIrq = (aMatch && stQ.compareAValue != `TPC_RST_CNT)
                               || (pMatch && !stQ.counterClearSelect);
                if (compareMode && aMatch && stQ.compareAValue != `TPC_RST_CNT)
                begin
                    unique case (stQ.pinFunction)
                        `TPC_PINF_00: stD.cmpLevel = stQ.cmpLevel;
                        `TPC_PINF_01: stD.cmpLevel = 1'b0;
                        `TPC_PINF_10: stD.cmpLevel = 1'b1;
                        `TPC_PINF_11: stD.cmpLevel = !stQ.cmpLevel;
                    endcase
                end
            end
        end

        // Capture acts even while stopped; it overrides a software write to compare A
        if (captureMode && capEdge)
        begin
            stD.compareAValue = stQ.counter; // RULE13
            stD.timerIrq      = 1'b1; // RULE13
        end

        if (stD.runEnable && !stQ.runEnable)
        begin
            stD.counter  = `TPC_RST_CNT; // RULE2 RULE7 RULE12
            stD.cmpLevel = stD.outputInitialLevel;
        end

        // Output follows the next state so pulse edge and run change land together
        // Active level from the next state too, else a level write glitches the pin for a cycle
        nextActive = stD.outputInitialLevel ^ stD.outputPolarity;
        unique case (stD.modeSelect)
            `TPC_MODE_PWM:
            begin
                if (stD.pinFunction == `TPC_PINF_11)
                begin
                    stD.pinLevel = stD.runEnable ? nextActive : !nextActive; // RULE4
                end
                else if (stD.pinFunction == `TPC_PINF_00)
                begin
                    stD.pinLevel = !nextActive;
                end
                else if (stD.pinFunction == `TPC_PINF_01)
                begin
                    stD.pinLevel = nextActive;
                end
                else
                begin
                    stD.pinLevel = (stD.counter < pwmDuty || pwmDuty >= pwmPeriod
                                    && pwmPeriod != `TPC_RST_CNT) ? nextActive : !nextActive;
                end
            end
            `TPC_MODE_CMP: stD.pinLevel = stD.cmpLevel;
            `TPC_MODE_CAP: stD.pinLevel = 1'b0; // RULE17
            `TPC_MODE_TMR: stD.pinLevel = 1'b0;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            stQ <= '0;
        end
        else
        begin
            stQ <= stD;
        end
    end

    assign regReadData = stQ.readData;
    assign pulseOut    = stQ.pinLevel;
    assign timerIrq    = stQ.timerIrq;

    a_start_clears_count: assert property (@(posedge clk) disable iff (rst) // RULE7
        $rose(stQ.runEnable) |-> stQ.counter == `TPC_RST_CNT)
        else $error("Counter not zero after run enable rise");

    a_match_ends_pulse: assert property (@(posedge clk) disable iff (rst) // RULE5
        singleMode && stQ.runEnable && aMatch |=> !stQ.runEnable && pulseOut == !$past(activeLevel))
        else $error("Compare A match did not end the pulse");

    a_match_raises_irq: assert property (@(posedge clk) disable iff (rst) // RULE6
        singleMode && stQ.runEnable && aMatch |=> timerIrq)
        else $error("Compare A match gave no interrupt");

    a_match_holds_count: assert property (@(posedge clk) disable iff (rst) // RULE7
        singleMode && stQ.runEnable && aMatch ##1 !stQ.runEnable && !regWrite && !extRise
        |=> stQ.counter == $past(stQ.counter, 2))
        else $error("Counter moved after compare A stop");

    a_ext_trigger_run: assert property (@(posedge clk) disable iff (rst) // RULE3
        singleMode && !stQ.runEnable && extRise |=> stQ.runEnable && stQ.counter == `TPC_RST_CNT)
        else $error("External trigger did not start pulse");

    a_pulse_out_level: assert property (@(posedge clk) disable iff (rst) // RULE4
        singleMode |-> pulseOut == (stQ.runEnable ? activeLevel : !activeLevel))
        else $error("Pulse output disagrees with run enable");

    a_capture_latch_value: assert property (@(posedge clk) disable iff (rst) // RULE13
        captureMode && capEdge |=> stQ.compareAValue == $past(stQ.counter) && timerIrq)
        else $error("Capture edge did not latch counter");

    a_capture_off_holds: assert property (@(posedge clk) disable iff (rst) // RULE16
        captureMode && stQ.pinFunction == `TPC_PINF_11 && !regWrite
        |=> stQ.compareAValue == $past(stQ.compareAValue))
        else $error("Capture occurred while disabled");

    a_pmatch_wraps_count: assert property (@(posedge clk) disable iff (rst) // RULE15
        captureMode && stQ.runEnable && pMatch && !(regWrite && regAddr == `TPC_ADDR_CTRL0)
        |=> stQ.counter == `TPC_RST_CNT && timerIrq)
        else $error("Compare P match did not clear counter");

    a_capture_no_output: assert property (@(posedge clk) disable iff (rst) // RULE17
        captureMode |-> !pulseOut)
        else $error("Capture mode drove the output");

    c_pulse_completes: cover property (@(posedge clk) disable iff (rst)
        singleMode && stQ.runEnable && aMatch ##1 timerIrq);

    c_capture_taken: cover property (@(posedge clk) disable iff (rst)
        captureMode && stQ.runEnable && capEdge);

    c_capture_wrap: cover property (@(posedge clk) disable iff (rst)
        captureMode && stQ.runEnable && pMatch);

endmodule // tpc_timer

`default_nettype wire

// ---- tb/tpc_pin_source.sv ----
`default_nettype none

module tpc_pin_source (
    input  wire logic clk,
    output var logic  extTimerClockPin,
    output var logic  captureInputPin
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        extTimerClockPin = 1'b0;
        captureInputPin  = 1'b0;
    end

    // Held three cycles so a synchronous sampler cannot miss it
    task automatic trigger();
        @(posedge clk);
        extTimerClockPin <= 1'b1;
        repeat (3) @(posedge clk);
        extTimerClockPin <= 1'b0;
    endtask

    task automatic setCapture(input logic level);
        @(posedge clk);
        captureInputPin <= level;
    endtask
endmodule // tpc_pin_source

`default_nettype wire

// ---- tb/tb.sv ----
`include "tpc_map.svh"
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic                   clk;
    logic                   rst;
    logic [`TPC_ADDR_W-1:0] regAddr;
    logic [15:0]            regWriteData;
    logic                   regWrite;
    logic                   regRead;
    logic [15:0]            regReadData;
    logic                   extTimerClockPin;
    logic                   captureInputPin;
    logic                   pulseOut;
    logic                   timerIrq;
    int                     bad_count;
    int                     samples_checked;
    logic [15:0]            highCount;
    logic [15:0]            irqCount;
    logic [15:0]            rdVal;
    logic [15:0]            heldVal;
    logic [15:0]            pwmCtrl [4] = '{16'h00A8, 16'h00A9, 16'h0088, 16'h0098};
    logic [15:0]            pwmHigh [4] = '{16'h001E, 16'h001E, 16'h0000, 16'h0050};

    tpc_timer i_tpc_timer (
        .clk              (clk),
        .rst              (rst),
        .regAddr          (regAddr),
        .regWriteData     (regWriteData),
        .regWrite         (regWrite),
        .regRead          (regRead),
        .regReadData      (regReadData),
        .extTimerClockPin (extTimerClockPin),
        .captureInputPin  (captureInputPin),
        .pulseOut         (pulseOut),
        .timerIrq         (timerIrq)
    );

    tpc_pin_source i_tpc_pin_source (
        .clk              (clk),
        .extTimerClockPin (extTimerClockPin),
        .captureInputPin  (captureInputPin)
    );

    task automatic chk(input logic [15:0] seen, input logic [15:0] expected);
        samples_checked++;
        if (seen !== expected)
        begin
            bad_count++;
            $display("[FAIL] %0t: seen %h expected %h", $time, seen, expected);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        regAddr      <= a;
        regWriteData <= d;
        regWrite     <= 1'b1;
        @(posedge clk);
        regWrite     <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, output logic [15:0] d);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1;
        d = regReadData;
    endtask

    // Samples just after each edge, so one-cycle pulses are never missed
    task automatic measure(input int cycles, output logic [15:0] w, output logic [15:0] q);
        w = 16'h0000;
        q = 16'h0000;
        repeat (cycles)
        begin
            @(posedge clk);
            #1;
            w = w + {15'h0000, pulseOut};
            q = q + {15'h0000, timerIrq};
        end
    endtask

    task automatic results();
        if (bad_count == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial
    begin
        #100000;
        bad_count++;
        results();
    end

    initial
    begin
        rst          = 1'b1;
        regAddr      = '0;
        regWriteData = 16'h0000;
        regWrite     = 1'b0;
        regRead      = 1'b0;
        bad_count    = 0;
        samples_checked = 0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        // Single pulse; compare P, clear select and exchange set to distract
        wr(`TPC_ADDR_CMPA, 16'h0005);
        wr(`TPC_ADDR_CMPP, 16'h0002);
        wr(`TPC_ADDR_CTRL1, 16'h00BB);
        fork
            wr(`TPC_ADDR_CTRL0, 16'h0001);
            measure(40, highCount, irqCount);
        join
        chk(highCount, 16'h0006);
        chk(irqCount, 16'h0001);
        rd(`TPC_ADDR_COUNT, rdVal);
        chk(rdVal, 16'h0005);
        rd(`TPC_ADDR_CTRL0, rdVal);
        chk(rdVal, 16'h0000);
        // Hardware start; second trigger lands mid-pulse
        fork
            begin
                i_tpc_pin_source.trigger();
                i_tpc_pin_source.trigger();
            end
            measure(40, highCount, irqCount);
        join
        chk(highCount, 16'h0006);
        chk(irqCount, 16'h0001);
        // Software ends a long pulse early
        wr(`TPC_ADDR_CMPA, 16'h0064);
        wr(`TPC_ADDR_CTRL0, 16'h0001);
        repeat (10) @(posedge clk);
        wr(`TPC_ADDR_CTRL0, 16'h0000);
        #1;
        chk({15'h0000, pulseOut}, 16'h0000);
        rd(`TPC_ADDR_COUNT, heldVal);
        rd(`TPC_ADDR_COUNT, rdVal);
        chk(rdVal, heldVal);
        // Capture on a stopped counter, every edge code
        for (int e = 0; e < 4; e++)
        begin
            wr(`TPC_ADDR_CTRL1, 16'(32'h4F | (e << 4)));
            wr(`TPC_ADDR_CMPA, 16'h0000);
            rd(`TPC_ADDR_COUNT, heldVal);
            fork
                begin
                    i_tpc_pin_source.setCapture(1'b1);
                    repeat (6) @(posedge clk);
                    i_tpc_pin_source.setCapture(1'b0);
                end
                measure(40, highCount, irqCount);
            join
            chk(irqCount, (e == 2) ? 16'h0002 : (e == 3) ? 16'h0000 : 16'h0001);
            chk(highCount, 16'h0000);
            rd(`TPC_ADDR_CMPA, rdVal);
            chk(rdVal, (e == 3) ? 16'h0000 : heldVal);
        end
        // Compare P bounds the running count
        wr(`TPC_ADDR_CMPP, 16'h0014);
        fork
            wr(`TPC_ADDR_CTRL0, 16'h0001);
            measure(40, highCount, irqCount);
        join
        chk(irqCount, 16'h0001);
        rd(`TPC_ADDR_COUNT, rdVal);
        chk(rdVal, 16'h0012);
        // Compare P of zero lets the count wrap past 3FF
        wr(`TPC_ADDR_CTRL0, 16'h0000);
        wr(`TPC_ADDR_CMPP, 16'h0000);
        fork
            wr(`TPC_ADDR_CTRL0, 16'h0001);
            measure(1100, highCount, irqCount);
        join
        chk(irqCount, 16'h0000);
        rd(`TPC_ADDR_COUNT, rdVal);
        chk(rdVal, 16'h004B);
        // Waveform: period 8, duty 3, clear select and forced levels
        wr(`TPC_ADDR_CMPP, 16'h0008);
        wr(`TPC_ADDR_CMPA, 16'h0003);
        for (int k = 0; k < 4; k++)
        begin
            wr(`TPC_ADDR_CTRL0, 16'h0000);
            wr(`TPC_ADDR_CTRL1, pwmCtrl[k]);
            wr(`TPC_ADDR_CTRL0, 16'h0001);
            measure(80, highCount, irqCount);
            chk(highCount, pwmHigh[k]);
            rd(`TPC_ADDR_COUNT, heldVal);
            rd(`TPC_ADDR_COUNT, rdVal);
            chk((rdVal - heldVal) & 16'h0007, 16'h0002);
        end
        results();
    end
endmodule // tb

`default_nettype wire
